//--- design/sector_fmt.sv
/*
  Soft-sector framing at the drive end plus a defect list sector parser.
  The link logic runs on the drive's byte clock (i_link_clk); controller
  strobes and read bytes arrive as pins and are synchronised there. The
  parser runs on i_clk and takes sector bytes from logic on that clock.
*/
`timescale 1ns/1ps
`include "sector_fmt_defines.svh"

// How it works
// [R1] Sector starts with 3-byte drive-chosen mark.
// [R2] Mark written only while both strobes high.
// [R3] Controller treats mark detection as sector start.
// [R4] Controller adds one pad byte after mark.
// [R5] Pad lets recovery window start late.
// [R6] Controller gap absorbs spindle speed variation.
// [R7] Controller fills track end up to origin.
// [R8] Reported configuration omits end-of-track filler length.
// [R9] Controller marks every preamble start explicitly.
// [R10] Mark request fall starts header preamble.
// [R11] Defect list optional; exact layout when present.
// [R12] List at sector 0, max cylinder, copy minus 8.
// [R13] Each surface lists only its own defects.
// [R14] 256 data bytes plus 2-byte check.
// [R15] Entries are 5 bytes, packed back to back.
// [R16] Controller allows 7-bit start position error.
// [R17] List ends at all-ones entry or sector end.
// [R18] Controller may skip check, rereading instead.
// [R19] Entry position counts bytes since track origin.
// [R20] Controller sends zeros in every preamble.
// [R21] Controller holds mark request 24 bit times; the bench model holds it 6 byte clocks.
// [R22] Recovery window only inside preamble, 11 bytes.
// [R23] Mark request alone starts mark search.
// [R24] Checker presets ones, compares stored check.
module sector_fmt #(
  parameter int MAX_CYL = 1023,
  parameter int POS_W = 16,
  parameter bit DL_ENABLE = 1'b1,
  parameter logic [15:0] SEP_GAP_BYTES = 16'h0010
) (
  // Clocks, reset and clock enable.
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_link_clk,
  // Controller strobes and track origin, pins on the link side.
  input wire logic i_record_window,
  input wire logic i_mark_req,
  input wire logic i_recovery_window,
  input wire logic i_track_origin,
  // Byte recovered from the media, pin on the link side.
  input wire logic [7:0] i_rd_byte,
  // Byte stream toward the write encoder, mark detection and byte position, link domain.
  output logic [7:0] o_wr_byte,
  output logic o_wr_en,
  output logic o_preamble_start,
  output logic o_mark_found_link,
  output logic [POS_W-1:0] o_byte_pos,
  // Mark detection carried into the core domain.
  output logic o_mark_found,
  // Defect list sector byte stream, core domain.
  input wire logic i_dl_start,
  input wire logic i_dl_valid,
  input wire logic [7:0] i_dl_byte,
  input wire logic [3:0] i_surface,
  // Parsed entries and list status.
  output sector_fmt_pkg::entry_t o_entry,
  output logic o_entry_valid,
  output logic [3:0] o_entry_surface,
  output logic o_list_done,
  output logic o_list_term,
  output logic o_crc_ok,
  // Where the list lives and what the configuration reports.
  output logic [15:0] o_dl_cyl,
  output logic [15:0] o_dl_cyl_copy,
  output logic [7:0] o_dl_sector,
  output logic [15:0] o_cfg_gap_bytes
);
  import sector_fmt_pkg::*;

  // Link domain: synchronisers for every pin and for the clock enable.
  logic [1:0] rw_s, mr_s, rg_s, org_s, ce_s;
  logic [7:0] rd_m, rd_s;
  logic rw, mr, rg, ce_l;
  logic mr_d, org_d;
  link_state_e lstate_r;
  logic [1:0] mark_cnt_r;
  logic [1:0] hit_cnt_r;
  logic mark_tgl_r;

  // Two flops per pin; only the second stage is read by logic.
  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rw_s <= 2'h0;
      mr_s <= 2'h0;
      rg_s <= 2'h0;
      org_s <= 2'h0;
      ce_s <= 2'h0;
      rd_m <= 8'h00;
      rd_s <= 8'h00;
    end else begin
      rw_s <= {rw_s[0], i_record_window};
      mr_s <= {mr_s[0], i_mark_req};
      rg_s <= {rg_s[0], i_recovery_window};
      org_s <= {org_s[0], i_track_origin};
      ce_s <= {ce_s[0], i_ce};
      rd_m <= i_rd_byte;
      rd_s <= rd_m;
    end
  end

  assign rw = rw_s[1];
  assign mr = mr_s[1];
  assign rg = rg_s[1];
  assign ce_l = ce_s[1];

  // Previous values for edge detection, taken from synchronised levels.
  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mr_d <= 1'b0;
      org_d <= 1'b0;
    end else if (ce_l) begin
      mr_d <= mr;
      org_d <= org_s[1];
    end
  end

  // Byte position since the track origin pulse, restarting on its edge.
  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_byte_pos <= '0;
    end else if (ce_l) begin
      if (org_s[1] && !org_d) begin
        o_byte_pos <= '0; // R19
      end else begin
        o_byte_pos <= o_byte_pos + 1'b1;
      end
    end
  end

  // Write framer. The mark is only laid down while both strobes are
  // high; once three bytes are out the drive holds and waits for the
  // request to fall, which pins down where the header preamble starts.
  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lstate_r <= l_idle;
      mark_cnt_r <= 2'h0;
      o_wr_byte <= `PREAMBLE_BYTE;
      o_wr_en <= 1'b0;
      o_preamble_start <= 1'b0;
    end else if (ce_l) begin
      o_preamble_start <= 1'b0;
      case (lstate_r)
        l_idle: begin
          o_wr_en <= 1'b0;
          o_wr_byte <= `PREAMBLE_BYTE;
          if (rw && mr) begin
            lstate_r <= l_mark; // R2
            mark_cnt_r <= 2'h0;
          end
        end
        l_mark: begin
          // A strobe dropping early aborts the mark.
          if (!(rw && mr)) begin
            lstate_r <= l_idle; // R2
            o_wr_en <= 1'b0;
          end else if (mark_cnt_r == `MARK_BYTES) begin
            lstate_r <= l_hold;
            o_wr_en <= 1'b0;
          end else begin
            o_wr_byte <= `MARK_PATTERN; // R1
            o_wr_en <= 1'b1;
            mark_cnt_r <= mark_cnt_r + 2'h1;
          end
        end
        l_hold: begin
          o_wr_en <= 1'b0;
          if (!rw) begin
            lstate_r <= l_idle;
          end else if (mr_d && !mr) begin
            lstate_r <= l_preamble; // R10
            o_preamble_start <= 1'b1;
            o_wr_byte <= `PREAMBLE_BYTE;
            o_wr_en <= 1'b1;
          end
        end
        l_preamble: begin
          // Preamble bytes continue until the record window closes.
          if (!rw) begin
            lstate_r <= l_idle;
            o_wr_en <= 1'b0;
          end else begin
            o_wr_byte <= `PREAMBLE_BYTE; // R10
            o_wr_en <= 1'b1;
          end
        end
        default: begin
          lstate_r <= l_idle;
          o_wr_en <= 1'b0;
        end
      endcase
    end
  end

  // Mark search: request alone, with neither window open, makes the
  // drive look for three mark bytes in a row on the read path.
  always_ff @(posedge i_link_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hit_cnt_r <= 2'h0;
      o_mark_found_link <= 1'b0;
      mark_tgl_r <= 1'b0;
    end else if (ce_l) begin
      o_mark_found_link <= 1'b0;
      if (!(mr && !rw && !rg) || rd_s != `MARK_PATTERN) begin
        hit_cnt_r <= 2'h0;
      end else if (hit_cnt_r == `MARK_BYTES - 2'h1) begin
        hit_cnt_r <= 2'h0;
        o_mark_found_link <= 1'b1; // R1
        mark_tgl_r <= ~mark_tgl_r;
      end else begin
        hit_cnt_r <= hit_cnt_r + 2'h1;
      end
    end
  end

  // Core domain: a toggle carries each detection across; comparing the
  // last two synchronised stages yields one pulse per event.
  logic [2:0] tgl_s;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tgl_s <= 3'h0;
      o_mark_found <= 1'b0;
    end else if (i_ce) begin
      tgl_s <= {tgl_s[1:0], mark_tgl_r};
      o_mark_found <= tgl_s[2] ^ tgl_s[1];
    end
  end

  // Fixed placement and configuration outputs. The report carries the
  // sector separation gap only; the end-of-track filler is left to the
  // controller since its length depends on the sectors laid down.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dl_cyl <= 16'(MAX_CYL); // R12
      o_dl_cyl_copy <= 16'(MAX_CYL) - `DL_COPY_OFFSET; // R12
      o_dl_sector <= `DL_SECTOR; // R12
      o_cfg_gap_bytes <= SEP_GAP_BYTES; // R8
    end
  end

  // Byte-wise check value update, most significant bit first.
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ `CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction : crc_step

  // Defect list parser state.
  parse_state_e pstate_r;
  logic [8:0] byte_cnt_r;
  logic [2:0] ent_idx_r;
  entry_t ent_r;
  entry_t ent_nxt;
  logic [15:0] crc_r;
  logic [15:0] rx_crc_r;
  logic crc_idx_r;

  assign ent_nxt = {ent_r[31:0], i_dl_byte};

  // Parser. The check runs over all 256 data bytes even after the
  // terminator, since the stored check covers the whole field. A partial
  // entry at the sector end is dropped: the field is not a multiple of 5.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pstate_r <= p_idle;
      byte_cnt_r <= 9'h000;
      ent_idx_r <= 3'h0;
      ent_r <= '0;
      crc_r <= `CRC_PRESET;
      rx_crc_r <= 16'h0000;
      crc_idx_r <= 1'b0;
      o_entry <= '0;
      o_entry_valid <= 1'b0;
      o_entry_surface <= 4'h0;
      o_list_done <= 1'b0;
      o_list_term <= 1'b0;
      o_crc_ok <= 1'b0;
    end else if (i_ce) begin
      o_entry_valid <= 1'b0;
      o_list_done <= 1'b0;
      case (pstate_r)
        p_idle: begin
          if (i_dl_start && DL_ENABLE) begin
            pstate_r <= p_data; // R11
            byte_cnt_r <= 9'h000;
            ent_idx_r <= 3'h0;
            crc_r <= `CRC_PRESET;
            o_list_term <= 1'b0;
            o_crc_ok <= 1'b0;
            o_entry_surface <= i_surface; // R13
          end
        end
        p_data: begin
          if (i_dl_valid) begin
            crc_r <= crc_step(crc_r, i_dl_byte); // R14
            ent_r <= ent_nxt;
            byte_cnt_r <= byte_cnt_r + 9'h001;
            if (ent_idx_r == `DL_ENTRY_LAST) begin
              ent_idx_r <= 3'h0; // R15
              if (!o_list_term) begin
                if (ent_nxt == `DL_END_ENTRY) begin
                  o_list_term <= 1'b1; // R17
                end else begin
                  o_entry <= ent_nxt; // R15
                  o_entry_valid <= 1'b1;
                end
              end
            end else begin
              ent_idx_r <= ent_idx_r + 3'h1;
            end
            if (byte_cnt_r == `DL_DATA_BYTES - 9'h001) begin
              pstate_r <= p_crc; // R17
              crc_idx_r <= 1'b0;
            end
          end
        end
        p_crc: begin
          if (i_dl_valid) begin
            rx_crc_r <= {rx_crc_r[7:0], i_dl_byte};
            crc_idx_r <= 1'b1;
            if (crc_idx_r) begin
              pstate_r <= p_done; // R14
            end
          end
        end
        p_done: begin
          o_crc_ok <= (rx_crc_r == crc_r); // R14
          o_list_done <= 1'b1;
          pstate_r <= p_idle;
        end
        default: begin
          pstate_r <= p_idle;
        end
      endcase
    end
  end
endmodule : sector_fmt

//--- design/sector_fmt_defines.svh
/*
  Named constants for the soft-sector framer and the defect list parser.
  Assumes it is included by bare name from the module.
*/
`ifndef SECTOR_FMT_DEFINES_SVH
`define SECTOR_FMT_DEFINES_SVH

// Sector mark length in bytes and its drive-chosen byte pattern.
`define MARK_BYTES 2'h3
`define MARK_PATTERN 8'ha1
// Preamble filler byte.
`define PREAMBLE_BYTE 8'h00
// Defect list sector layout.
`define DL_DATA_BYTES 9'h100
`define DL_CRC_BYTES 2'h2
`define DL_ENTRY_BYTES 3'h5
`define DL_ENTRY_LAST 3'h4
`define DL_SECTOR 8'h00
`define DL_COPY_OFFSET 16'h0008
// Check value: generator x^16 + x^12 + x^5 + 1, preset all ones.
`define CRC_POLY 16'h1021
`define CRC_PRESET 16'hffff
// An entry of all ones ends a surface's list.
`define DL_END_ENTRY 40'hff_ffff_ffff

`endif

//--- design/sector_fmt_pkg.sv
/*
  Types shared by the sector framer: the state enumerations of both
  clock domains and the defect entry type. Assumes the defines header is on the include path.
*/
package sector_fmt_pkg;
  // Link-side framer states.
  typedef enum logic [1:0] {
    l_idle,
    l_mark,
    l_hold,
    l_preamble
  } link_state_e;

  // Defect list parser states.
  typedef enum logic [1:0] {
    p_idle,
    p_data,
    p_crc,
    p_done
  } parse_state_e;

  // Defect entry as five packed bytes, first byte highest.
  typedef logic [39:0] entry_t;
endpackage : sector_fmt_pkg

//--- test/sector_fmt_properties.sv
/* Checker for the sector framer's ports, both clock domains.
   Assumes it is bound to sector_fmt from the bench top file. */
`timescale 1ns/1ps
module sector_fmt_properties #(
  parameter int MAX_CYL = 1023,
  parameter int POS_W = 16,
  parameter logic [15:0] SEP_GAP_BYTES = 16'h0010
) (
  input wire logic i_clk, i_link_clk, i_arst_n,
  input wire logic i_record_window, i_mark_req, i_track_origin,
  input wire logic [7:0] o_wr_byte, o_dl_sector,
  input wire logic o_wr_en, o_preamble_start,
  input wire logic [POS_W-1:0] o_byte_pos,
  input wire sector_fmt_pkg::entry_t o_entry,
  input wire logic o_entry_valid, o_list_term,
  input wire logic [15:0] o_dl_cyl, o_dl_cyl_copy, o_cfg_gap_bytes
);
  // A mark is three pattern bytes back to back, then a pause.
  sequence mark_burst;
    (o_wr_en && o_wr_byte == 8'ha1) [*3] ##1 !o_wr_en;
  endsequence
  a_mark_length: assert property (@(posedge i_link_clk)
    disable iff (!i_arst_n) $rose(o_wr_en) && o_wr_byte == 8'ha1 |-> mark_burst)
    else $error("mark burst has the wrong length");
  a_mark_gated: assert property (@(posedge i_link_clk)
    disable iff (!i_arst_n) o_wr_en && o_wr_byte == 8'ha1
    |-> $past(i_record_window, 2) && $past(i_mark_req, 2))
    else $error("mark written without both strobes");
  a_write_stops: assert property (@(posedge i_link_clk)
    disable iff (!i_arst_n) (!i_record_window) [*3] |=> !o_wr_en)
    else $error("writing with the record window low");
  a_preamble_on_fall: assert property (@(posedge i_link_clk)
    disable iff (!i_arst_n)
    $fell(i_mark_req) && i_record_window |-> ##[1:4] o_preamble_start)
    else $error("no preamble start after request fall");
  a_preamble_zero: assert property (@(posedge i_link_clk)
    disable iff (!i_arst_n)
    o_preamble_start |-> o_wr_en && o_wr_byte == 8'h00)
    else $error("preamble does not start with a zero byte");
  a_origin_zero: assert property (@(posedge i_link_clk)
    disable iff (!i_arst_n) $rose(i_track_origin) |-> ##[1:5] o_byte_pos == '0)
    else $error("byte position not cleared at origin");
  // Entries need five bytes each, so two pulses never touch.
  a_entry_pulse: assert property (@(posedge i_clk)
    disable iff (!i_arst_n) o_entry_valid |=> !o_entry_valid)
    else $error("entry pulses back to back");
  a_entry_not_end: assert property (@(posedge i_clk)
    disable iff (!i_arst_n)
    o_entry_valid |-> o_entry != 40'hff_ffff_ffff && !o_list_term)
    else $error("entry reported at or after the end marker");
  a_list_place: assert property (@(posedge i_clk)
    disable iff (!i_arst_n) o_dl_cyl == 16'(MAX_CYL)
    && o_dl_cyl_copy == 16'(MAX_CYL - 8) && o_dl_sector == 8'h00)
    else $error("defect list location wrong");
  a_gap_report: assert property (@(posedge i_clk)
    disable iff (!i_arst_n) o_cfg_gap_bytes == SEP_GAP_BYTES)
    else $error("reported gap figure wrong");
endmodule : sector_fmt_properties

//--- test/ctl_model.sv
/* Controller model: record window, mark request and media bytes.
   Assumes a free-running drive byte clock. */
`timescale 1ns/1ps
module ctl_model #(
  parameter int HOLD = 6
) (
  input wire logic i_link_clk,
  input wire logic i_go_wr,
  input wire logic i_go_srch,
  output logic o_rw,
  output logic o_mr,
  output logic [7:0] o_rd
);
  logic srch_r;
  initial begin
    o_rw = 1'b0;
    o_mr = 1'b0;
    o_rd = 8'h5a;
    srch_r = 1'b0;
  end
  // Media bytes flip when no mark passes, so no two stale bytes in a row match.
  always @(posedge i_link_clk) begin
    #1 o_rd = srch_r ? 8'ha1 : ~o_rd;
  end
  // Format write: both strobes, then the request falls to start a preamble.
  always @(posedge i_go_wr) begin
    @(posedge i_link_clk);
    #1 o_rw = 1'b1;
    o_mr = 1'b1;
    // The request spans the mark and the pad byte behind it.
    repeat (HOLD) @(posedge i_link_clk);
    #1 o_mr = 1'b0;
    // The drive lays down zeros; the recovery window stays low here.
    repeat (HOLD) @(posedge i_link_clk);
    #1 o_rw = 1'b0;
  end
  // Search: request alone while exactly one mark passes under the head.
  always @(posedge i_go_srch) begin
    @(posedge i_link_clk);
    srch_r = 1'b1;
    #1 o_mr = 1'b1;
    repeat (3) @(posedge i_link_clk);
    srch_r = 1'b0;
    repeat (HOLD - 3) @(posedge i_link_clk);
    #1 o_mr = 1'b0;
  end
endmodule : ctl_model

//--- test/sector_fmt_tb.sv
/* Bench for sector_fmt: the controller model drives record window, mark request and
   read bytes, the bench the other pins and the defect sectors. Assumes the package is compiled first. */
`timescale 1ns/1ps
module sector_fmt_tb;
  import sector_fmt_pkg::*;
  logic i_clk = 0, i_link_clk = 0, i_arst_n = 0, i_track_origin = 0;
  logic go_wr = 0, go_srch = 0, rw, mr, done;
  logic rg = 0, mfl;
  logic [15:0] o_byte_pos;
  logic [3:0] o_entry_surface;
  logic [7:0] rd, o_wr_byte, i_dl_byte = 0, o_dl_sector;
  logic o_wr_en, o_preamble_start, o_mark_found, o_list_done;
  logic i_dl_start = 0, i_dl_valid = 0, o_entry_valid, o_list_term, o_crc_ok;
  logic [3:0] i_surface = 0;
  logic [15:0] o_dl_cyl, o_dl_cyl_copy, o_cfg_gap_bytes;
  entry_t o_entry, first;
  int num_errors = 0, cmp_count = 0, ents, mfl_cnt = 0;
  always #2 i_clk = ~i_clk;
  always #7.5 i_link_clk = ~i_link_clk;
  // Link-side detection pulses, each counted once at the next byte edge.
  always @(posedge i_link_clk) if (mfl === 1'b1) mfl_cnt++;
  ctl_model #(.HOLD(6)) u_ctl (.i_link_clk(i_link_clk), .i_go_wr(go_wr),
    .i_go_srch(go_srch), .o_rw(rw), .o_mr(mr), .o_rd(rd));
  sector_fmt #(.MAX_CYL(100), .SEP_GAP_BYTES(16'h0020)) dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1), .i_link_clk(i_link_clk),
    .i_record_window(rw), .i_mark_req(mr), .i_recovery_window(rg),
    .i_track_origin(i_track_origin), .i_rd_byte(rd), .o_wr_byte(o_wr_byte),
    .o_wr_en(o_wr_en), .o_preamble_start(o_preamble_start),
    .o_mark_found_link(mfl), .o_byte_pos(o_byte_pos),
    .o_mark_found(o_mark_found),
    .i_dl_start(i_dl_start), .i_dl_valid(i_dl_valid), .i_dl_byte(i_dl_byte),
    .i_surface(i_surface), .o_entry(o_entry), .o_entry_valid(o_entry_valid),
    .o_entry_surface(o_entry_surface), .o_list_done(o_list_done),
    .o_list_term(o_list_term),
    .o_crc_ok(o_crc_ok), .o_dl_cyl(o_dl_cyl), .o_dl_cyl_copy(o_dl_cyl_copy),
    .o_dl_sector(o_dl_sector), .o_cfg_gap_bytes(o_cfg_gap_bytes));
  task chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task give_verdict;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // Bit-serial check value, high bit first, kept apart from the design.
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : crc_byte
  task t_consts;
    chk(o_dl_cyl, 16'h0064);
    chk(o_dl_cyl_copy, 16'h005c);
    chk(o_dl_sector, 8'h00);
    chk(o_cfg_gap_bytes, 16'h0020);
  endtask : t_consts
  // Origin edge: the count restarts at zero, then advances once per byte.
  task automatic t_origin;
    @(posedge i_link_clk) #1 i_track_origin = 1;
    repeat (3) @(posedge i_link_clk) #1;
    chk(o_byte_pos, 40'h0);
    repeat (10) @(posedge i_link_clk) #1;
    chk(o_byte_pos, 40'ha);
    i_track_origin = 0;
  endtask : t_origin
  task automatic t_mark_write;
    int k;
    @(posedge i_clk) #1 go_wr = 1;
    for (k = 0; k < 40 && o_wr_en !== 1'b1; k++) @(posedge i_link_clk) #1;
    chk(o_wr_en, 1'b1);
    if (k == 40) give_verdict();
    for (k = 0; k < 3; k++) begin
      chk(o_wr_byte, 8'ha1);
      @(posedge i_link_clk) #1;
    end
    chk(o_wr_en, 1'b0);
    for (k = 0; k < 40 && o_preamble_start !== 1'b1; k++)
      @(posedge i_link_clk) #1;
    chk(o_wr_byte, 8'h00);
    if (k == 40) give_verdict();
    for (k = 0; k < 40 && o_wr_en !== 1'b0; k++) @(posedge i_link_clk) #1;
    chk(o_wr_en, 1'b0);
    go_wr = 0;
  endtask : t_mark_write
  // Search with the recovery window open must find nothing; closed, once.
  task automatic t_mark_search(input bit gate);
    int k, n0;
    n0 = mfl_cnt;
    rg = gate;
    @(posedge i_clk) #1 go_srch = 1;
    for (k = 0; k < 100 && o_mark_found !== 1'b1; k++) @(posedge i_clk) #1;
    chk(o_mark_found, !gate);
    if (k == 100 && !gate) give_verdict();
    chk(o_wr_en, 1'b0);
    @(posedge i_clk) #1 chk(o_mark_found, 1'b0);
    repeat (2) @(posedge i_link_clk) #1;
    chk(mfl_cnt - n0, !gate);
    go_srch = 0;
  endtask : t_mark_search
  // One core cycle, noting entries and the end of the sector.
  task step;
    @(posedge i_clk) #1;
    if (o_entry_valid === 1'b1) begin
      if (ents == 0) first = o_entry;
      ents++;
    end
    if (o_list_done === 1'b1) done = 1;
  endtask : step
  task automatic t_parse(input bit term, input bit bad);
    logic [15:0] c;
    int k;
    c = 16'hffff;
    ents = 0;
    done = 0;
    i_surface = {3'h2, term};
    i_dl_start = 1;
    step();
    for (k = 0; k < 258; k++) begin
      i_dl_byte = k < 5 ? 8'(k + 1) : (term && k < 10) ? 8'hff : 8'(k);
      if (k > 255) i_dl_byte = k == 256 ? c[15:8] : c[7:0] ^ {7'h0, bad};
      else c = crc_byte(c, i_dl_byte);
      i_dl_valid = 1;
      i_dl_start = (k == 20);
      step();
      if (k == 7) begin
        i_dl_valid = 0;
        step();
      end
    end
    i_dl_valid = 0;
    for (k = 0; k < 10 && !done; k++) step();
    chk(done, 1'b1);
    if (k == 10) give_verdict();
    chk(first, 40'h01_0203_0405);
    chk(ents, term ? 1 : 51);
    chk(o_list_term, term);
    chk(o_crc_ok, !bad);
    chk(o_entry_surface, {3'h2, term});
  endtask : t_parse
  initial begin
    repeat (2) @(posedge i_clk);
    #1 i_arst_n = 1;
    repeat (4) @(posedge i_link_clk);
    t_consts();
    t_origin();
    t_mark_write();
    t_mark_search(1'b1);
    t_mark_search(1'b0);
    t_parse(1'b1, 1'b0);
    t_parse(1'b0, 1'b1);
    give_verdict();
  end
endmodule : sector_fmt_tb

bind sector_fmt sector_fmt_properties #(.MAX_CYL(MAX_CYL), .POS_W(POS_W),
  .SEP_GAP_BYTES(SEP_GAP_BYTES)) u_props (.i_clk(i_clk),
  .i_link_clk(i_link_clk), .i_arst_n(i_arst_n), .i_mark_req(i_mark_req),
  .i_record_window(i_record_window), .i_track_origin(i_track_origin),
  .o_wr_byte(o_wr_byte), .o_dl_sector(o_dl_sector), .o_wr_en(o_wr_en),
  .o_preamble_start(o_preamble_start), .o_byte_pos(o_byte_pos),
  .o_entry(o_entry), .o_entry_valid(o_entry_valid), .o_dl_cyl(o_dl_cyl),
  .o_list_term(o_list_term), .o_dl_cyl_copy(o_dl_cyl_copy),
  .o_cfg_gap_bytes(o_cfg_gap_bytes));
